// file: rtl/ubt_defines.svh
// register map, field positions, reset values and timing counts of the serial transmitter
`ifndef UBT_DEFINES_SVH
`define UBT_DEFINES_SVH
`define UBT_OFF_CTRL_ONE 12'h000
`define UBT_OFF_CTRL_TWO 12'h004
`define UBT_OFF_STATUS 12'h008
`define UBT_OFF_DIVISOR 12'h00c
`define UBT_OFF_TXBUF 12'h010
// serial_control_one fields
`define UBT_C1_GLOBAL 7
`define UBT_C1_WORDLEN 6
`define UBT_C1_PAREN 5
`define UBT_C1_PARTYPE 4
`define UBT_C1_STOP_BIT_SELECT 3
`define UBT_C1_BREAK 2
`define UBT_C1_NINTH 0
// serial_control_two fields
`define UBT_C2_TRANSMIT_ENABLE 7
`define UBT_C2_RECEIVE_ENABLE 6
`define UBT_C2_SPEED 5
`define UBT_C2_TRANSMIT_EMPTY_IRQ_ENABLE 0
// serial_status_register fields
`define UBT_ST_TXEMPTY 0
`define UBT_ST_TXIDLE 1
`define UBT_ST_RXIDLE 2
// reset values
`define UBT_RST_BYTE 8'h00
`define UBT_RST_DIVISOR 8'h00
// baud prescale: last step of 64 (low speed) or 16 (high speed)
`define UBT_PRE_LOW 6'h3f
`define UBT_PRE_HIGH 6'h0f
// frame lengths in bits: start + word + stop_bit_select
`define UBT_LEN_BASE 4'h1
`define UBT_WORD8 4'h8
`define UBT_WORD9 4'h9
`define UBT_STOP1 4'h1
`define UBT_STOP2 4'h2
`define UBT_FRAME_IDLE 12'hfff
`endif

// file: rtl/ubt_pkg.sv
// types of the serial baud generator and transmitter
package ubt_pkg;
   typedef struct packed {
      logic global_en;
      logic word9;
      logic par_en;
      logic par_odd;
      logic stop2;
      logic brk;
      logic ninth;
   } ubt_ctrl_one_t;

   typedef struct packed {
      logic tx_en;
      logic rx_en;
      logic speed_hi;
      logic transmit_empty_irq_enable;
   } ubt_ctrl_two_t;

   typedef struct packed {
      ubt_ctrl_one_t c1;
      ubt_ctrl_two_t c2;
      logic [7:0] divisor;
      logic [7:0] timer;
      logic [5:0] presc;
      logic [8:0] txbuf;
      logic buf_full;
      logic [11:0] shift;
      logic [3:0] bits_left;
      logic busy;
      logic empty_flag;
      logic idle_flag;
      logic armed;
      logic line;
      logic irq;
      logic [31:0] prdata;
      logic pslverr;
      logic ack;
   } ubt_state_t;
endpackage : ubt_pkg

// file: rtl/ubt_top.sv
// serial baud generator, frame format control and transmit path with an APB slave
`include "ubt_defines.svh"

module ubt_top (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // serial line
   output logic tx_out,
   output logic tx_oe_out,
   output logic rx_en_out,
   // transmit empty request
   output logic tx_irq_out
);
   ubt_pkg::ubt_state_t state_ff;
   ubt_pkg::ubt_state_t nxt_state;

   function automatic logic [12:0] build_frame(input logic [8:0] w,
                                               input ubt_pkg::ubt_ctrl_one_t c);
      logic [11:0] fr;
      logic [8:0] word;
      logic par;
      fr = `UBT_FRAME_IDLE;
      word = w;
      par = c.word9 ? ^w[7:0] : ^w[6:0];
      if (c.par_odd) begin
         par = ~par;
      end
      if (c.par_en) begin
         if (c.word9) begin
            word[8] = par;
         end else begin
            word[7] = par;
         end
      end
      if (c.word9) begin
         fr[9:1] = word;
      end else begin
         fr[8:1] = word[7:0];
      end
      // start bit; the stop positions keep the idle level
      fr[0] = 1'b0;
      return {1'b0, fr};
   endfunction : build_frame

   function automatic logic [3:0] frame_len(input ubt_pkg::ubt_ctrl_one_t c);
      frame_len = `UBT_LEN_BASE + (c.word9 ? `UBT_WORD9 : `UBT_WORD8)
                  + (c.stop2 ? `UBT_STOP2 : `UBT_STOP1);
   endfunction : frame_len

   logic apb_wr;
   logic apb_first;
   logic apb_done;
   logic hit;
   logic [5:0] presc_last;
   logic bit_tick;
   logic tx_on;
   logic [12:0] frame;

   always_comb begin
      nxt_state = state_ff;
      // one wait state: the register is read at the first access edge so that read data
      // comes from flip-flops, and writes take effect at the edge that sees pready high
      apb_first = psel_in & penable_in & ~state_ff.ack;
      apb_done = psel_in & penable_in & state_ff.ack;
      apb_wr = apb_done & pwrite_in;
      nxt_state.ack = apb_first;
      hit = 1'b0;
      frame = 13'h0000;
      presc_last = state_ff.c2.speed_hi ? `UBT_PRE_HIGH : `UBT_PRE_LOW;
      bit_tick = (state_ff.timer == state_ff.divisor) && (state_ff.presc == presc_last);
      tx_on = state_ff.c1.global_en & state_ff.c2.tx_en;
      // free-running divisor timer feeding the prescaler
      if (state_ff.timer == state_ff.divisor) begin
         nxt_state.timer = `UBT_RST_DIVISOR;
         nxt_state.presc = (state_ff.presc == presc_last) ? 6'h00 : state_ff.presc + 6'h01;
      end else begin
         nxt_state.timer = state_ff.timer + 8'h01;
      end
      // shift out one bit per baud period, LSB first
      if (state_ff.busy && bit_tick) begin
         if (state_ff.bits_left == 4'h1) begin
            nxt_state.busy = 1'b0;
            nxt_state.idle_flag = 1'b1;
         end else begin
            nxt_state.shift = {1'b1, state_ff.shift[11:1]};
            nxt_state.bits_left = state_ff.bits_left - 4'h1;
         end
      end
      // reload only once the stop bits are out
      if (!nxt_state.busy && state_ff.buf_full && tx_on) begin
         frame = build_frame(state_ff.txbuf, state_ff.c1);
         nxt_state.shift = frame[11:0];
         nxt_state.bits_left = frame_len(state_ff.c1);
         nxt_state.busy = 1'b1;
         nxt_state.buf_full = 1'b0;
         nxt_state.empty_flag = 1'b1;
         // restart the baud phase so the start bit is a full period
         nxt_state.timer = `UBT_RST_DIVISOR;
         nxt_state.presc = 6'h00;
      end
      // apb access
      nxt_state.pslverr = 1'b0;
      nxt_state.prdata = 32'h0000_0000;
      if (apb_first || apb_done) begin
         case (paddr_in)
            `UBT_OFF_CTRL_ONE: begin
               hit = 1'b1;
               nxt_state.prdata[`UBT_C1_GLOBAL] = state_ff.c1.global_en;
               nxt_state.prdata[`UBT_C1_WORDLEN] = state_ff.c1.word9;
               nxt_state.prdata[`UBT_C1_PAREN] = state_ff.c1.par_en;
               nxt_state.prdata[`UBT_C1_PARTYPE] = state_ff.c1.par_odd;
               nxt_state.prdata[`UBT_C1_STOP_BIT_SELECT] = state_ff.c1.stop2;
               nxt_state.prdata[`UBT_C1_BREAK] = state_ff.c1.brk;
               nxt_state.prdata[`UBT_C1_NINTH] = state_ff.c1.ninth;
               if (apb_wr) begin
                  nxt_state.c1.global_en = pwdata_in[`UBT_C1_GLOBAL];
                  nxt_state.c1.word9 = pwdata_in[`UBT_C1_WORDLEN];
                  nxt_state.c1.par_en = pwdata_in[`UBT_C1_PAREN];
                  nxt_state.c1.par_odd = pwdata_in[`UBT_C1_PARTYPE];
                  nxt_state.c1.stop2 = pwdata_in[`UBT_C1_STOP_BIT_SELECT];
                  nxt_state.c1.brk = pwdata_in[`UBT_C1_BREAK];
                  nxt_state.c1.ninth = pwdata_in[`UBT_C1_NINTH];
               end
            end
            `UBT_OFF_CTRL_TWO: begin
               hit = 1'b1;
               nxt_state.prdata[`UBT_C2_TRANSMIT_ENABLE] = state_ff.c2.tx_en;
               nxt_state.prdata[`UBT_C2_RECEIVE_ENABLE] = state_ff.c2.rx_en;
               nxt_state.prdata[`UBT_C2_SPEED] = state_ff.c2.speed_hi;
               nxt_state.prdata[`UBT_C2_TRANSMIT_EMPTY_IRQ_ENABLE] = state_ff.c2.transmit_empty_irq_enable;
               if (apb_wr) begin
                  nxt_state.c2.tx_en = pwdata_in[`UBT_C2_TRANSMIT_ENABLE];
                  nxt_state.c2.rx_en = pwdata_in[`UBT_C2_RECEIVE_ENABLE];
                  nxt_state.c2.speed_hi = pwdata_in[`UBT_C2_SPEED];
                  nxt_state.c2.transmit_empty_irq_enable = pwdata_in[`UBT_C2_TRANSMIT_EMPTY_IRQ_ENABLE];
               end
            end
            `UBT_OFF_STATUS: begin
               hit = 1'b1;
               nxt_state.prdata[`UBT_ST_TXEMPTY] = state_ff.empty_flag;
               nxt_state.prdata[`UBT_ST_TXIDLE] = state_ff.idle_flag;
               // receiver is outside this block and always reads idle
               nxt_state.prdata[`UBT_ST_RXIDLE] = 1'b1;
               if (apb_done) begin
                  nxt_state.armed = 1'b1;
               end
            end
            `UBT_OFF_DIVISOR: begin
               hit = 1'b1;
               nxt_state.prdata[7:0] = state_ff.divisor;
               if (apb_wr) begin
                  nxt_state.divisor = pwdata_in[7:0];
               end
            end
            `UBT_OFF_TXBUF: begin
               hit = 1'b1;
               // a pending character is overwritten by a later write unless a status read came before the first write
               if (apb_wr && state_ff.empty_flag) begin
                  nxt_state.txbuf = {state_ff.c1.ninth, pwdata_in[7:0]};
                  nxt_state.buf_full = 1'b1;
                  if (state_ff.armed) begin
                     nxt_state.empty_flag = 1'b0;
                     nxt_state.idle_flag = 1'b0;
                  end
                  nxt_state.armed = 1'b0;
               end
            end
            default: begin
               hit = 1'b0;
            end
         endcase
         // the answer of the first access edge stands in the cycle that pready marks
         if (apb_first) begin
            nxt_state.pslverr = ~hit;
         end else begin
            nxt_state.prdata = 32'h0000_0000;
         end
      end
      // transmit disable aborts the frame the buffer is emptied only as the enable
      // falls, so a character written while disabled waits for the enable
      if (!nxt_state.c2.tx_en) begin
         nxt_state.busy = 1'b0;
         if (state_ff.c2.tx_en) begin
            nxt_state.buf_full = 1'b0;
            nxt_state.empty_flag = 1'b1;
         end
      end
      // global disable resets transfer state and clears tx_en, rx_en and brk, keeps the rest of the config
      if (!nxt_state.c1.global_en) begin
         nxt_state.c2.tx_en = 1'b0;
         nxt_state.c2.rx_en = 1'b0;
         nxt_state.c1.brk = 1'b0;
         nxt_state.busy = 1'b0;
         nxt_state.buf_full = 1'b0;
         nxt_state.empty_flag = 1'b1;
         nxt_state.idle_flag = 1'b1;
         nxt_state.armed = 1'b0;
      end
      // line rests high outside a frame
      nxt_state.line = nxt_state.busy ? nxt_state.shift[0] : 1'b1;
      nxt_state.irq = nxt_state.empty_flag & nxt_state.c2.transmit_empty_irq_enable;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_ff <= '0;
         state_ff.empty_flag <= 1'b1;
         state_ff.idle_flag <= 1'b1;
         state_ff.line <= 1'b1;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign prdata_out = state_ff.prdata;
   assign pready_out = state_ff.ack;
   assign pslverr_out = state_ff.pslverr;
   assign tx_out = state_ff.line;
   assign tx_oe_out = state_ff.c1.global_en & state_ff.c2.tx_en;
   assign rx_en_out = state_ff.c1.global_en & state_ff.c2.rx_en;
   assign tx_irq_out = state_ff.irq;
endmodule : ubt_top

// file: tb/ubt_chk.sv
// port assertions for the serial transmitter
module ubt_chk (
   // clock, reset and bus
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   // serial line
   input wire logic tx_out,
   input wire logic tx_oe_out,
   input wire logic rx_en_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic wr;
   assign wr = psel_in && penable_in && pwrite_in && pready_out;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   a_pready_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
      else $error("pready late");
   a_err_cause: assert property (pslverr_out |-> $past(psel_in && penable_in))
      else $error("stray slverr");
   a_read_rest: assert property (!$past(psel_in && penable_in) |-> prdata_out == 32'h0)
      else $error("stray read data");
   a_idle_high: assert property (!tx_oe_out && !$fell(tx_oe_out) |-> tx_out)
      else $error("line low while released");
   a_oe_cause: assert property ($rose(tx_oe_out) |-> $past(wr))
      else $error("pin taken without a write");
   a_global_off: assert property (wr && paddr_in == 12'h000 && !pwdata_in[7]
      |=> !tx_oe_out && !rx_en_out) else $error("global disable ignored");
   a_tx_off: assert property (wr && paddr_in == 12'h004 && !pwdata_in[7]
      |=> !tx_oe_out ##[0:1] tx_out) else $error("transmit disable ignored");
   // shortest bit is 16 clocks, so any low level must last at least 8
   a_bit_min: assert property ($fell(tx_out) |-> (!tx_out || !tx_oe_out) [*8])
      else $error("bit too short");
endmodule : ubt_chk

bind ubt_top ubt_chk u_chk (.clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
   .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .tx_out, .tx_oe_out, .rx_en_out);

// file: tb/ubt_rx_model.sv
// receiving peer that samples the serial line in mid-bit
module ubt_rx_model (
   // clock and line
   input wire logic clk_in,
   input wire logic line_in,
   input wire logic oe_in,
   // expected frame shape
   input var int bit_len_in,
   input var int nbits_in,
   // captured frame, start bit at index 0
   output logic [11:0] word_out,
   output int frames_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      word_out = 12'h000;
      frames_out = 0;
      forever begin
         @(posedge clk_in);
         if (oe_in === 1'b1 && line_in === 1'b0) begin
            repeat (bit_len_in / 2) @(posedge clk_in);
            for (int i = 0; i < nbits_in; i++) begin
               word_out[i] = line_in;
               if (i < nbits_in - 1) repeat (bit_len_in) @(posedge clk_in);
            end
            frames_out++;
         end
      end
   end
endmodule : ubt_rx_model

// file: tb/ubt_top_tb.sv
// self-checking bench for the serial transmitter
module ubt_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0;
   logic [31:0] prdata_out;
   logic pready_out, pslverr_out, tx_out, tx_oe_out, rx_en_out, tx_irq_out;
   logic [31:0] rd;
   logic err;
   logic [11:0] word;
   int bit_len = 16;
   int nbits = 10;
   int frames;
   int fail_count = 0;
   int tests_run = 0;
   always #25 clk_in = ~clk_in;
   ubt_top uut (.clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
      .prdata_out, .pready_out, .pslverr_out, .tx_out, .tx_oe_out, .rx_en_out, .tx_irq_out);
   ubt_rx_model peer (.clk_in, .line_in(tx_out), .oe_in(tx_oe_out), .bit_len_in(bit_len),
      .nbits_in(nbits), .word_out(word), .frames_out(frames));
   // read data and error are taken at the edge that sees pready high, then released
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      @(posedge clk_in);
      while (pready_out !== 1'b1) @(posedge clk_in);
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      // one more edge so that what the access changed has settled before a check
      @(posedge clk_in);
   endtask : apb
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
         fail_count++;
      end
   endtask : chk
   task automatic wait_frames(input int n);
      int k;
      k = frames + n;
      for (int i = 0; i < 30000 && frames < k; i++) @(posedge clk_in);
      if (frames < k) begin
         $display("CHECK FAILED frames expected %0d seen %0d", k, frames);
         fail_count++;
      end
   endtask : wait_frames
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out
   task automatic t_reset;
      apb(0, 12'h000, 0);
      chk("ctrl_one", 32'h0, rd);
      apb(0, 12'h004, 0);
      chk("ctrl_two", 32'h0, rd);
      apb(0, 12'h008, 0);
      chk("status", 32'h7, rd);
      apb(0, 12'h020, 0);
      chk("unmapped", 1, err);
      chk("irq masked", 0, tx_irq_out);
      $display("test reset done");
   endtask : t_reset
   task automatic t_held;
      int f0;
      f0 = frames;
      apb(1, 12'h000, 32'h80);
      apb(1, 12'h00c, 32'h0);
      apb(0, 12'h008, 0);
      apb(1, 12'h010, 32'h11);
      apb(1, 12'h004, 32'ha1);
      apb(0, 12'h008, 0);
      apb(1, 12'h010, 32'h22);
      apb(1, 12'h010, 32'h33);
      apb(0, 12'h008, 0);
      chk("status full", 32'h4, rd);
      chk("irq full", 0, tx_irq_out);
      wait_frames(2);
      chk("held frame", {3'b001, 8'h22, 1'b0}, word);
      repeat (300) @(posedge clk_in);
      chk("frames", f0 + 2, frames);
      chk("irq empty", 1, tx_irq_out);
      $display("test held done");
   endtask : t_held
   task automatic t_abort(input logic [11:0] a, input logic [31:0] v, input logic [31:0] ex);
      apb(1, 12'h000, 32'h80);
      apb(1, 12'h004, 32'he0);
      apb(0, 12'h008, 0);
      apb(1, 12'h010, 32'h0);
      repeat (40) @(posedge clk_in);
      apb(1, a, v);
      chk("released", 0, tx_oe_out);
      apb(0, 12'h004, 0);
      chk("ctrl_two", ex, rd);
      chk("line high", 1, tx_out);
      chk("rx enable", ex[6], rx_en_out);
      repeat (800) @(posedge clk_in);
      $display("test abort done");
   endtask : t_abort
   task automatic t_frame(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] dv,
      input logic [7:0] d, input logic [11:0] ex, input int nb, input int bl);
      bit_len = bl;
      nbits = nb;
      apb(1, 12'h000, {24'h0, c1});
      apb(1, 12'h00c, {24'h0, dv});
      apb(1, 12'h004, {24'h0, c2});
      apb(0, 12'h008, 0);
      apb(1, 12'h010, {24'h0, d});
      apb(0, 12'h008, 0);
      chk("status busy", 32'h5, rd);
      chk("owned", 1, tx_oe_out);
      wait_frames(1);
      chk("frame", ex, word & ((12'h1 << nb) - 12'h1));
      repeat (bl) @(posedge clk_in);
      apb(0, 12'h008, 0);
      chk("status done", 32'h7, rd);
      $display("test frame %h done", ex);
   endtask : t_frame
   initial begin
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      t_reset;
      t_held;
      t_abort(12'h004, 32'h60, 32'h60);
      t_abort(12'h000, 32'h0, 32'h20);
      t_frame(8'h80, 8'ha0, 8'h01, 8'ha5, {3'b001, 8'ha5, 1'b0}, 10, 32);
      t_frame(8'hc9, 8'h80, 8'h00, 8'h0f, {3'b111, 8'h0f, 1'b0}, 12, 64);
      t_frame(8'ha0, 8'h80, 8'h00, 8'h07, {4'b0011, 7'h07, 1'b0}, 10, 64);
      t_frame(8'hb0, 8'ha0, 8'h02, 8'h07, {4'b0010, 7'h07, 1'b0}, 10, 48);
      close_out;
   end
   initial begin
      #2000000;
      fail_count++;
      close_out;
   end
endmodule : ubt_top_tb
